// *** inc/usb_suspend_wakeup_control_consts.svh ***
// offsets, field positions, reset values and counts of the suspend and wakeup controller
`ifndef USB_SUSPEND_WAKEUP_CONTROL_CONSTS_SVH
`define USB_SUSPEND_WAKEUP_CONTROL_CONSTS_SVH

`define SWC_ADDR_W          4
`define SWC_OFS_CTRL        4'h0
`define SWC_OFS_WAKE_EN     4'h1
`define SWC_OFS_GPIO_EN     4'h2
`define SWC_OFS_STATUS      4'h3
`define SWC_OFS_MASK        4'h4
`define SWC_OFS_STATE       4'h5

`define SWC_CTRL_VARIANT_LSB 0
`define SWC_CTRL_VARIANT_W   2
`define SWC_VARIANT_RESET    2'h2

`define SWC_EN_GPIO         0
`define SWC_EN_WOL          1
`define SWC_EN_PKT          2
`define SWC_EN_LINK         3
`define SWC_EN_W            4
`define SWC_WAKE_EN_RESET   4'h0
`define SWC_GPIO_EN_RESET   8'hff

`define SWC_ST_WAKEUP       0
`define SWC_ST_GPIO         1
`define SWC_ST_WOL          2
`define SWC_ST_PKT          3
`define SWC_ST_LINK         4
`define SWC_ST_W            5

`define SWC_GPIO_COUNT      8

`endif

// *** inc/usb_suspend_wakeup_control_pkg.sv ***
// types of the suspend and wakeup controller
`include "usb_suspend_wakeup_control_consts.svh"

package usb_suspend_wakeup_control_pkg;

    typedef enum logic [1:0] {
        suspend_variant_full_wake = 2'h0,
        suspend_variant_link_wake = 2'h1,
        suspend_variant_pin_wake  = 2'h2,
        suspend_variant_spare     = 2'h3
    } variant_type;

    // path 00 -> 01 -> 11 -> 00: awake -> suspended -> waking -> awake; the last step flips both bits
    typedef enum logic [1:0] {
        fsm_awake     = 2'b00,
        fsm_suspended = 2'b01,
        fsm_waking    = 2'b11
    } fsm_type;

    typedef struct packed {
        logic mac_clk_en;
        logic aux_clk_en;
        logic phy_power_en;
        logic frame_detect_en;
    } power_type;

    typedef struct packed {
        logic wol_frame;
        logic wake_packet;
        logic link_change;
    } eth_event_type;

endpackage : usb_suspend_wakeup_control_pkg

// *** rtl/usb_suspend_wakeup_control.sv ***
// suspend variant selection, wake source gating and remote wakeup request
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "usb_suspend_wakeup_control_consts.svh"

module usb_suspend_wakeup_control #(
    parameter int GPIO_COUNT = `SWC_GPIO_COUNT
) (
    // clock and reset
    input  wire logic                                     sys_clk,
    input  wire logic                                     rst,
    // avalon-mm slave
    input  wire logic [`SWC_ADDR_W-1:0]                   avs_address,
    input  wire logic                                     avs_read,
    input  wire logic                                     avs_write,
    input  wire logic [31:0]                              avs_writedata,
    output logic      [31:0]                              avs_readdata,
    output logic                                          avs_waitrequest,
    // usb upstream side
    input  wire logic                                     usb_suspend,
    output logic                                          remote_wakeup,
    // wake sources
    input  wire logic [GPIO_COUNT-1:0]                    gpio_in,
    input  wire usb_suspend_wakeup_control_pkg::eth_event_type eth_event,
    // power controls
    output usb_suspend_wakeup_control_pkg::power_type     power,
    // interrupt
    output logic                                          irq
);

    typedef struct packed {
        usb_suspend_wakeup_control_pkg::fsm_type     fsm;
        usb_suspend_wakeup_control_pkg::variant_type variant;
        logic [`SWC_EN_W-1:0]                        wake_en;
        logic [GPIO_COUNT-1:0]                       gpio_en;
        logic [`SWC_ST_W-1:0]                        status;
        logic [`SWC_ST_W-1:0]                        mask;
        logic [GPIO_COUNT-1:0]                       gpio_prev;
        logic [31:0]                                 readdata;
        logic                                        waitrequest;
        logic                                        remote_wakeup;
        usb_suspend_wakeup_control_pkg::power_type   power;
        logic                                        irq;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // bus handshake
    logic                  access_done;
    logic                  wr_hit;
    // wake source decode
    logic [GPIO_COUNT-1:0] gpio_rise;
    logic                  gpio_hit;
    logic                  wol_hit;
    logic                  pkt_hit;
    logic                  link_hit;
    logic                  any_hit;
    logic                  is_suspended;
    // status and read-back
    logic [`SWC_ST_W-1:0]  events;
    logic [`SWC_ST_W-1:0]  w1c;
    logic [31:0]           rd_value;
    usb_suspend_wakeup_control_pkg::power_type power_sel;

    // everything on while awake, and whenever a wakeup has been requested
    localparam usb_suspend_wakeup_control_pkg::power_type power_all_on = '{
        mac_clk_en:      1'b1,
        aux_clk_en:      1'b1,
        phy_power_en:    1'b1,
        frame_detect_en: 1'b1
    };

    // full-wake keeps the phy and frame detection up so wake frames can still be seen
    localparam usb_suspend_wakeup_control_pkg::power_type power_full_wake = '{
        mac_clk_en:      1'b0,
        aux_clk_en:      1'b0,
        phy_power_en:    1'b1,
        frame_detect_en: 1'b1
    };

    // link-wake keeps only the phy powered, enough to notice a link change
    localparam usb_suspend_wakeup_control_pkg::power_type power_link_wake = '{
        mac_clk_en:      1'b0,
        aux_clk_en:      1'b0,
        phy_power_en:    1'b1,
        frame_detect_en: 1'b0
    };

    // pin-wake turns everything off; only a gpio edge can wake it
    localparam usb_suspend_wakeup_control_pkg::power_type power_pin_wake = '{
        mac_clk_en:      1'b0,
        aux_clk_en:      1'b0,
        phy_power_en:    1'b0,
        frame_detect_en: 1'b0
    };

    // per-pin assertion detect; inputs are synchronous to sys_clk
    genvar g;
    generate
        for (g = 0; g < GPIO_COUNT; g = g + 1) begin : gen_gpio
            assign gpio_rise[g] = gpio_in[g] & ~state_reg.gpio_prev[g] & state_reg.gpio_en[g];
        end
    endgenerate

    always_comb begin
        access_done  = (avs_read | avs_write) & ~state_reg.waitrequest;
        wr_hit       = avs_write & ~state_reg.waitrequest;
        is_suspended = (state_reg.fsm == usb_suspend_wakeup_control_pkg::fsm_suspended);

        // gpio is permitted in every variant
        gpio_hit = is_suspended & state_reg.wake_en[`SWC_EN_GPIO] & (|gpio_rise);
        wol_hit  = 1'b0;
        pkt_hit  = 1'b0;
        link_hit = 1'b0;
        case (state_reg.variant)
            usb_suspend_wakeup_control_pkg::suspend_variant_full_wake: begin
                wol_hit = is_suspended & state_reg.wake_en[`SWC_EN_WOL] & eth_event.wol_frame;
                pkt_hit = is_suspended & state_reg.wake_en[`SWC_EN_PKT] & eth_event.wake_packet;
            end
            usb_suspend_wakeup_control_pkg::suspend_variant_link_wake: begin
                link_hit = is_suspended & state_reg.wake_en[`SWC_EN_LINK] & eth_event.link_change;
            end
            usb_suspend_wakeup_control_pkg::suspend_variant_pin_wake: begin
                wol_hit  = 1'b0;
                pkt_hit  = 1'b0;
                link_hit = 1'b0;
            end
            default: begin
                // spare code behaves as pin-wake: ethernet events are dropped
                link_hit = 1'b0;
            end
        endcase
        any_hit = gpio_hit | wol_hit | pkt_hit | link_hit;

        // power level per variant while suspended; all on when awake
        power_sel = power_all_on;
        if (is_suspended) begin
            case (state_reg.variant)
                usb_suspend_wakeup_control_pkg::suspend_variant_full_wake: begin
                    power_sel = power_full_wake;
                end
                usb_suspend_wakeup_control_pkg::suspend_variant_link_wake: begin
                    power_sel = power_link_wake;
                end
                usb_suspend_wakeup_control_pkg::suspend_variant_pin_wake: begin
                    power_sel = power_pin_wake;
                end
                default: begin
                    // spare code: same level as pin-wake
                    power_sel = power_pin_wake;
                end
            endcase
        end

        events = '0;
        events[`SWC_ST_WAKEUP] = any_hit;
        events[`SWC_ST_GPIO]   = gpio_hit;
        events[`SWC_ST_WOL]    = wol_hit;
        events[`SWC_ST_PKT]    = pkt_hit;
        events[`SWC_ST_LINK]   = link_hit;

        w1c = '0;
        if (wr_hit && avs_address == `SWC_OFS_STATUS) begin
            w1c = avs_writedata[`SWC_ST_W-1:0];
        end

        rd_value = 32'h0;
        case (avs_address)
            `SWC_OFS_CTRL: begin
                rd_value[`SWC_CTRL_VARIANT_W-1:0] = state_reg.variant;
            end
            `SWC_OFS_WAKE_EN: begin
                rd_value[`SWC_EN_W-1:0] = state_reg.wake_en;
            end
            `SWC_OFS_GPIO_EN: begin
                rd_value[GPIO_COUNT-1:0] = state_reg.gpio_en;
            end
            `SWC_OFS_STATUS: begin
                rd_value[`SWC_ST_W-1:0] = state_reg.status;
            end
            `SWC_OFS_MASK: begin
                rd_value[`SWC_ST_W-1:0] = state_reg.mask;
            end
            `SWC_OFS_STATE: begin
                rd_value[1:0] = state_reg.fsm;
                rd_value[3]   = state_reg.power.mac_clk_en;
            end
            default: begin
                rd_value = 32'h0;
            end
        endcase

        state_next               = state_reg;
        state_next.gpio_prev     = gpio_in;
        state_next.remote_wakeup = 1'b0;

        // one wait cycle, then the access completes with waitrequest low
        // back-to-back requests see waitrequest 1, 0, 1, 0; masters need no cycle count
        if ((avs_read | avs_write) && state_reg.waitrequest) begin
            state_next.waitrequest = 1'b0;
            state_next.readdata    = avs_read ? rd_value : 32'h0;
        end else begin
            state_next.waitrequest = 1'b1;
        end
        if (access_done && avs_read) begin
            state_next.readdata = rd_value;
        end

        if (wr_hit) begin
            case (avs_address)
                `SWC_OFS_CTRL: begin
                    state_next.variant = usb_suspend_wakeup_control_pkg::variant_type'(
                        avs_writedata[`SWC_CTRL_VARIANT_LSB +: `SWC_CTRL_VARIANT_W]);
                end
                `SWC_OFS_WAKE_EN: begin
                    state_next.wake_en = avs_writedata[`SWC_EN_W-1:0];
                end
                `SWC_OFS_GPIO_EN: begin
                    state_next.gpio_en = avs_writedata[GPIO_COUNT-1:0];
                end
                `SWC_OFS_MASK: begin
                    state_next.mask = avs_writedata[`SWC_ST_W-1:0];
                end
                default: begin
                    // status is write-one-clear below; state and unmapped words ignore writes
                    state_next.mask = state_reg.mask;
                end
            endcase
        end

        // set wins over a write-one clear in the same cycle
        state_next.status = (state_reg.status & ~w1c) | events;
        state_next.irq    = |(state_next.status & state_next.mask);

        case (state_reg.fsm)
            usb_suspend_wakeup_control_pkg::fsm_awake: begin
                if (usb_suspend) begin
                    state_next.fsm = usb_suspend_wakeup_control_pkg::fsm_suspended;
                end
            end
            usb_suspend_wakeup_control_pkg::fsm_suspended: begin
                if (!usb_suspend) begin
                    state_next.fsm = usb_suspend_wakeup_control_pkg::fsm_awake;
                end else if (any_hit) begin
                    state_next.fsm           = usb_suspend_wakeup_control_pkg::fsm_waking;
                    state_next.remote_wakeup = 1'b1;
                end
            end
            usb_suspend_wakeup_control_pkg::fsm_waking: begin
                // hold off further requests until the host resumes the bus
                if (!usb_suspend) begin
                    state_next.fsm = usb_suspend_wakeup_control_pkg::fsm_awake;
                end
            end
            default: begin
                // the unused code returns to awake rather than locking up
                state_next.fsm = usb_suspend_wakeup_control_pkg::fsm_awake;
            end
        endcase

        // clocks come back as soon as a wakeup is requested; on entry the level
        // drops one cycle after the state, since power_sel looks at the registered state
        state_next.power = power_sel;
        if (state_next.fsm != usb_suspend_wakeup_control_pkg::fsm_suspended) begin
            state_next.power = power_all_on;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg.fsm           <= usb_suspend_wakeup_control_pkg::fsm_awake;
            state_reg.variant       <= usb_suspend_wakeup_control_pkg::variant_type'(`SWC_VARIANT_RESET);
            state_reg.wake_en       <= `SWC_WAKE_EN_RESET;
            state_reg.gpio_en       <= {GPIO_COUNT{1'b1}};
            state_reg.status        <= '0;
            state_reg.mask          <= '0;
            // a pin already high at release reads as a rise; harmless, suspend entry takes a cycle
            state_reg.gpio_prev     <= '0;
            state_reg.readdata      <= 32'h0;
            state_reg.waitrequest   <= 1'b1;
            state_reg.remote_wakeup <= 1'b0;
            state_reg.power         <= power_all_on;
            state_reg.irq           <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign avs_readdata    = state_reg.readdata;
    assign avs_waitrequest = state_reg.waitrequest;
    assign remote_wakeup   = state_reg.remote_wakeup;
    assign power           = state_reg.power;
    assign irq             = state_reg.irq;

endmodule : usb_suspend_wakeup_control

// *** test/usb_suspend_wakeup_control_assertions.sv ***
// port-level checks of the suspend and wakeup controller
`timescale 1ns/1ps
`include "usb_suspend_wakeup_control_consts.svh"
module usb_suspend_wakeup_control_checker #(
    parameter int GPIO_COUNT = `SWC_GPIO_COUNT
) (
    input wire logic                                       sys_clk,
    input wire logic                                       rst,
    input wire logic [`SWC_ADDR_W-1:0]                     avs_address,
    input wire logic                                       avs_read,
    input wire logic                                       avs_write,
    input wire logic [31:0]                                avs_writedata,
    input wire logic [31:0]                                avs_readdata,
    input wire logic                                       avs_waitrequest,
    input wire logic                                       usb_suspend,
    input wire logic                                       remote_wakeup,
    input wire logic [GPIO_COUNT-1:0]                      gpio_in,
    input wire usb_suspend_wakeup_control_pkg::eth_event_type eth_event,
    input wire usb_suspend_wakeup_control_pkg::power_type  power,
    input wire logic                                       irq
);
    logic [1:0]            var_q;
    logic [GPIO_COUNT-1:0] g1;
    logic [GPIO_COUNT-1:0] g2;
    logic                  g_rise;
    // variant shadow taken from completed bus writes, since it is not a port
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            var_q <= `SWC_VARIANT_RESET;
            g1    <= '0;
            g2    <= '0;
        end else begin
            g1 <= gpio_in;
            g2 <= g1;
            if (avs_write && !avs_waitrequest && avs_address == `SWC_OFS_CTRL)
                var_q <= (avs_writedata[1:0] == 2'h3) ? 2'h2 : avs_writedata[1:0];
        end
    end
    assign g_rise = |(g1 & ~g2);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after request");
    property p_one_low; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
    property p_drop; $fell(power.mac_clk_en) |-> $past(usb_suspend) && $past(usb_suspend, 2); endproperty
    a_drop: assert property (p_drop) else $error("clocks stopped without suspend");
    property p_full_pw; $fell(power.mac_clk_en) && var_q == 2'h0 |-> power == 4'h3; endproperty
    a_full_pw: assert property (p_full_pw) else $error("full-wake power level wrong");
    property p_link_pw; $fell(power.mac_clk_en) && var_q == 2'h1 |-> power == 4'h2; endproperty
    a_link_pw: assert property (p_link_pw) else $error("link-wake power level wrong");
    property p_pin_pw; $fell(power.mac_clk_en) && var_q == 2'h2 |-> power == 4'h0; endproperty
    a_pin_pw: assert property (p_pin_pw) else $error("pin-wake power level wrong");
    property p_pulse; $rose(remote_wakeup) |-> power == 4'hf ##1 !remote_wakeup [*3]; endproperty
    a_pulse: assert property (p_pulse) else $error("wakeup pulse or power restore wrong");
    property p_wake_full;
        remote_wakeup && var_q == 2'h0 |-> g_rise || $past(eth_event.wol_frame) || $past(eth_event.wake_packet);
    endproperty
    a_wake_full: assert property (p_wake_full) else $error("full-wake woke without cause");
    property p_wake_link; remote_wakeup && var_q == 2'h1 |-> g_rise || $past(eth_event.link_change); endproperty
    a_wake_link: assert property (p_wake_link) else $error("link-wake woke without cause");
    property p_wake_pin; remote_wakeup && var_q == 2'h2 |-> g_rise; endproperty
    a_wake_pin: assert property (p_wake_pin) else $error("pin-wake woke without pin rise");
    c_full: cover property (remote_wakeup && var_q == 2'h0);
    c_link: cover property (remote_wakeup && var_q == 2'h1);
    c_pin: cover property (remote_wakeup && var_q == 2'h2);
endmodule : usb_suspend_wakeup_control_checker

bind usb_suspend_wakeup_control usb_suspend_wakeup_control_checker #(.GPIO_COUNT(GPIO_COUNT)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .usb_suspend(usb_suspend), .remote_wakeup(remote_wakeup), .gpio_in(gpio_in), .eth_event(eth_event),
    .power(power), .irq(irq));

// *** test/usb_host_model.sv ***
// upstream host: suspends the bus on request, resumes after a wakeup
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       suspend_req,
    input  wire logic [3:0] resume_delay,
    input  wire logic       remote_wakeup,
    output logic            usb_suspend
);
    logic [3:0] cnt;
    logic       resuming;
    // a slow host keeps the bus suspended for a while after the wakeup
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            usb_suspend <= 1'b0;
            resuming    <= 1'b0;
            cnt         <= 4'h0;
        end else if (!suspend_req) begin
            usb_suspend <= 1'b0;
            resuming    <= 1'b0;
        end else if (remote_wakeup) begin
            resuming <= 1'b1;
            cnt      <= resume_delay;
        end else if (resuming) begin
            if (cnt == 4'h0) usb_suspend <= 1'b0;
            else cnt <= cnt - 4'h1;
        end else usb_suspend <= 1'b1;
    end
endmodule : usb_host_model

// *** test/tb_usb_suspend_wakeup_control.sv ***
// self-checking bench of the suspend and wakeup controller
`timescale 1ns/1ps
module tb_usb_suspend_wakeup_control;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        usb_suspend;
    logic        remote_wakeup;
    logic        suspend_req = 1'b0;
    logic [3:0]  resume_delay = 4'h0;
    logic [7:0]  gpio_in = 8'h00;
    usb_suspend_wakeup_control_pkg::eth_event_type eth_event = 3'h0;
    usb_suspend_wakeup_control_pkg::power_type     power;
    logic        irq;
    logic [31:0] rd;
    logic [4:0]  mask_now = 5'h00;
    int          error_cnt = 0;
    int          n_checks = 0;
    int          cyc = 0;
    usb_suspend_wakeup_control #(.GPIO_COUNT(8)) uut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .usb_suspend(usb_suspend), .remote_wakeup(remote_wakeup),
        .gpio_in(gpio_in), .eth_event(eth_event), .power(power), .irq(irq));
    usb_host_model host (.sys_clk(sys_clk), .rst(rst), .suspend_req(suspend_req), .resume_delay(resume_delay),
        .remote_wakeup(remote_wakeup), .usb_suspend(usb_suspend));
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic chk(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : chk
    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic try_wake(input logic [1:0] v, input logic [3:0] en, input logic [7:0] gen,
                            input logic [7:0] g, input logic [2:0] e, input logic [4:0] st);
        int n;
        n = 0;
        bus(1'b1, 4'h0, {30'h0, v});
        bus(1'b1, 4'h1, {28'h0, en});
        bus(1'b1, 4'h2, {24'h0, gen});
        suspend_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk(power === ((v == 2'h0) ? 4'h3 : (v == 2'h1) ? 4'h2 : 4'h0), "power");
        bus(1'b0, 4'h5, 32'h0);
        chk(rd === 32'h1, "state while suspended");
        @(posedge sys_clk);
        gpio_in <= g;
        eth_event <= e;
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            eth_event <= 3'h0;
            #1 if (remote_wakeup === 1'b1) n++;
        end
        chk(n == st[0], "wake pulse count");
        chk(irq === |(st & mask_now), "irq level");
        @(posedge sys_clk);
        suspend_req <= 1'b0;
        gpio_in <= 8'h00;
        bus(1'b0, 4'h3, 32'h0);
        chk(rd === {27'h0, st}, "status bits");
        bus(1'b1, 4'h3, 32'h1f);
        @(posedge sys_clk);
        #1 chk(irq === 1'b0, "irq after clear");
    endtask : try_wake
    task automatic t_reset_values();
        bus(1'b0, 4'h0, 32'h0);
        chk(rd === 32'h2, "variant after reset");
        bus(1'b0, 4'h1, 32'h0);
        chk(rd === 32'h0, "wake enables after reset");
        bus(1'b0, 4'h2, 32'h0);
        chk(rd === 32'hff, "pin enables after reset");
        bus(1'b0, 4'h5, 32'h0);
        chk(rd === 32'h8, "state after reset");
        bus(1'b1, 4'h9, 32'hffff);
        bus(1'b0, 4'h9, 32'h0);
        chk(rd === 32'h0, "unmapped index");
        $display("t_reset_values done");
    endtask : t_reset_values
    task automatic t_pin_variant();
        try_wake(2'h2, 4'hf, 8'hff, 8'h00, 3'h7, 5'h00);
        try_wake(2'h2, 4'h0, 8'hff, 8'h01, 3'h0, 5'h00);
        try_wake(2'h3, 4'hf, 8'hff, 8'h20, 3'h0, 5'h03);
        $display("t_pin_variant done");
    endtask : t_pin_variant
    task automatic t_full_variant();
        mask_now = 5'h1f;
        bus(1'b1, 4'h4, 32'h1f);
        try_wake(2'h0, 4'hf, 8'hff, 8'h00, 3'h1, 5'h00);
        try_wake(2'h0, 4'h2, 8'hff, 8'h00, 3'h4, 5'h05);
        try_wake(2'h0, 4'h2, 8'hff, 8'h00, 3'h2, 5'h00);
        try_wake(2'h0, 4'h4, 8'hff, 8'h00, 3'h2, 5'h09);
        $display("t_full_variant done");
    endtask : t_full_variant
    task automatic t_link_variant();
        @(posedge sys_clk);
        resume_delay <= 4'h7;
        try_wake(2'h1, 4'hf, 8'hff, 8'h00, 3'h6, 5'h00);
        try_wake(2'h1, 4'h8, 8'hff, 8'h00, 3'h1, 5'h11);
        try_wake(2'h1, 4'h1, 8'hfe, 8'h01, 3'h0, 5'h00);
        try_wake(2'h1, 4'h1, 8'h80, 8'h81, 3'h0, 5'h03);
        $display("t_link_variant done");
    endtask : t_link_variant
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_values();
        t_pin_variant();
        t_full_variant();
        t_link_variant();
        tally_and_finish();
    end
endmodule : tb_usb_suspend_wakeup_control
